// file: hdl/tmw_defs.vh
// constants for the 8-bit waveform timer
`ifndef TMW_DEFS_VH
`define TMW_DEFS_VH
// ----------------------------------------
// register offsets (word addresses, one 32-bit register each)
// ----------------------------------------
`define TMW_ADDR_CTRL 4'h0
`define TMW_ADDR_PRESC 4'h1
`define TMW_ADDR_COUNT 4'h2
`define TMW_ADDR_CMPA 4'h3
`define TMW_ADDR_CMPB 4'h4
`define TMW_ADDR_FLAGS 4'h5
`define TMW_ADDR_DIR 4'h6
// ----------------------------------------
// control field and flag bit positions
// ----------------------------------------
`define TMW_CTRL_MODE_LO 0
`define TMW_CTRL_MODE_HI 2
`define TMW_CTRL_SETA_LO 4
`define TMW_CTRL_SETA_HI 5
`define TMW_CTRL_SETB_LO 6
`define TMW_CTRL_SETB_HI 7
`define TMW_FLAG_OVF 0
`define TMW_FLAG_CMPA 1
`define TMW_FLAG_CMPB 2
// ----------------------------------------
// modes, settings, values
// ----------------------------------------
`define TMW_MODE_NORMAL 3'h0
`define TMW_MODE_PC_FF 3'h1
`define TMW_MODE_CTC 3'h2
`define TMW_MODE_FAST_FF 3'h3
`define TMW_MODE_PC_A 3'h5
`define TMW_MODE_FAST_A 3'h7
`define TMW_SET_OFF 2'h0
`define TMW_SET_TOGGLE 2'h1
`define TMW_SET_CLEAR 2'h2
`define TMW_SET_SET 2'h3
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hFF
`define TMW_PSC_STOP 3'h0
`define TMW_PSC_1 3'h1
`define TMW_PSC_8 3'h2
`define TMW_PSC_64 3'h3
`define TMW_PSC_256 3'h4
`define TMW_PSC_1024 3'h5
`define TMW_DIV_8 10'h007
`define TMW_DIV_64 10'h03F
`define TMW_DIV_256 10'h0FF
`define TMW_DIV_1024 10'h3FF
`define TMW_RD_ZERO 32'h00000000
`endif

// file: hdl/tmw_prescaler.v
// prescaler producing the timer tick enable
`timescale 1ns/1ps
module tmw_prescaler (
  // clock and reset
  input wire clk,
  input wire rst,
  // selection
  input wire [2:0] psc_sel,
  // tick enable
  output reg tick
);
`include "tmw_defs.vh"
  reg [9:0] div_q;
  reg [9:0] lim;
  // terminal count for the chosen factor
  always @* begin
    case (psc_sel)
      `TMW_PSC_8: lim = `TMW_DIV_8;
      `TMW_PSC_64: lim = `TMW_DIV_64;
      `TMW_PSC_256: lim = `TMW_DIV_256;
      `TMW_PSC_1024: lim = `TMW_DIV_1024;
      default: lim = 10'h000;
    endcase
  end
  // divide by 1, 8, 64, 256, 1024
  always @* begin
    if (psc_sel == `TMW_PSC_STOP || psc_sel > `TMW_PSC_1024) begin
      tick = 1'b0;
    end else if (psc_sel == `TMW_PSC_1) begin
      tick = 1'b1;
    end else begin
      tick = (div_q == lim);
    end
  end
  // free-running divider, restarts at terminal count
  always @(posedge clk) begin
    if (rst) begin
      div_q <= 10'h000;
    end else if (tick || psc_sel == `TMW_PSC_STOP) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end
endmodule

// file: hdl/tmw_timer.v
// 8-bit waveform timer top with avalon-mm register slave
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module tmw_timer (
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // port pin fallback levels
  input wire port_level_a,
  input wire port_level_b,
  // pins
  output wire pin_out_a,
  output wire pin_oe_a,
  output wire pin_out_b,
  output wire pin_oe_b,
  // internal state view
  output wire [7:0] count_value,
  output wire wave_out_a,
  output wire wave_out_b
);
`include "tmw_defs.vh"

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] ctrl_q;
  reg [2:0] psc_q;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg down_q;
  reg down_d;
  reg [2:0] flags_q;
  reg [1:0] dir_q;
  reg blk_q;
  reg rd_done_q;
  wire tick;
  wire [2:0] waveform_mode_sel;
  wire waveform_mode_upper_bit;
  wire [1:0] compare_output_setting_a;
  wire [1:0] compare_output_setting_b;
  wire [7:0] compare_value_a;
  wire [7:0] compare_value_b;
  wire [7:0] buf_a;
  wire [7:0] buf_b;
  wire match_a;
  wire match_b;
  wire overflow_flag;
  wire compare_flag_a;
  wire compare_flag_b;

  assign waveform_mode_sel = ctrl_q[`TMW_CTRL_MODE_HI:`TMW_CTRL_MODE_LO];
  assign waveform_mode_upper_bit = ctrl_q[`TMW_CTRL_MODE_HI];
  assign compare_output_setting_a = ctrl_q[`TMW_CTRL_SETA_HI:`TMW_CTRL_SETA_LO];
  assign compare_output_setting_b = ctrl_q[`TMW_CTRL_SETB_HI:`TMW_CTRL_SETB_LO];
  assign overflow_flag = flags_q[`TMW_FLAG_OVF];
  assign compare_flag_a = flags_q[`TMW_FLAG_CMPA];
  assign compare_flag_b = flags_q[`TMW_FLAG_CMPB];
  assign count_value = count_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // write one register selected by address
  function sel;
    input [3:0] addr;
    input [3:0] want;
    begin
      sel = (addr == want);
    end
  endfunction

  // writes finish at once; reads take one wait cycle for registered data
  wire wr = avs_write && avs_byteenable[0];
  wire rd_req = avs_read && !rd_done_q;
  assign avs_waitrequest = rd_req;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // fast pwm; phase correct; clear on match
  wire is_fast = (waveform_mode_sel == `TMW_MODE_FAST_FF) ||
                 (waveform_mode_sel == `TMW_MODE_FAST_A);
  wire is_pc = (waveform_mode_sel == `TMW_MODE_PC_FF) ||
               (waveform_mode_sel == `TMW_MODE_PC_A);
  wire is_ctc = (waveform_mode_sel == `TMW_MODE_CTC);
  wire is_pwm = is_fast || is_pc;
  wire top_is_a = (waveform_mode_sel == `TMW_MODE_FAST_A) ||
                  (waveform_mode_sel == `TMW_MODE_PC_A) || is_ctc;
  // TOP 0xFF gives 256 ticks fast
  // TOP 0xFF gives 510 ticks phase correct
  wire [7:0] top_value = top_is_a ? compare_value_a : `TMW_MAX;
  wire at_top = (count_q == top_value);
  wire at_bottom = (count_q == `TMW_BOTTOM);

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  tmw_prescaler u_psc (
    .clk(clk),
    .rst(rst),
    .psc_sel(psc_q),
    .tick(tick)
  );

  // ----------------------------------------
  // compare channels
  // ----------------------------------------
  tmw_wave_unit u_ch_a (
    .clk(clk),
    .rst(rst),
    .wr_cmp(wr && sel(avs_address, `TMW_ADDR_CMPA)),
    .wr_data(avs_writedata[7:0]),
    .setting(compare_output_setting_a),
    .toggle_ok(waveform_mode_upper_bit || !is_pwm),
    .tick(tick),
    .is_pwm(is_pwm),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .count_up(!down_q),
    .count_value(count_q),
    .top_value(top_value),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .block_match(blk_q),
    .compare_value_n(compare_value_a),
    .cmp_buf_q(buf_a),
    .match(match_a),
    .wave_out_n(wave_out_a)
  );

  // channel b never offers the pwm toggle
  tmw_wave_unit u_ch_b (
    .clk(clk),
    .rst(rst),
    .wr_cmp(wr && sel(avs_address, `TMW_ADDR_CMPB)),
    .wr_data(avs_writedata[7:0]),
    .setting(compare_output_setting_b),
    .toggle_ok(!is_pwm),
    .tick(tick),
    .is_pwm(is_pwm),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .count_up(!down_q),
    .count_value(count_q),
    .top_value(top_value),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .block_match(blk_q),
    .compare_value_n(compare_value_b),
    .cmp_buf_q(buf_b),
    .match(match_b),
    .wave_out_n(wave_out_b)
  );

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // next count and direction per mode
  always @* begin
    count_d = count_q;
    down_d = down_q;
    if (is_pc) begin
      // hold top one tick, then reverse
      if (at_top) begin
        down_d = 1'b1;
        count_d = count_q - 8'h01;
      end else if (down_q && at_bottom) begin
        down_d = 1'b0;
        count_d = count_q + 8'h01;
      end else if (down_q) begin
        count_d = count_q - 8'h01;
      end else begin
        count_d = count_q + 8'h01;
      end
    end else begin
      down_d = 1'b0;
      // clear at compare A; clear after top
      // above top the count wraps through 0xFF
      if ((is_ctc || is_fast) && at_top) begin
        count_d = `TMW_BOTTOM;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  // counter register, a software write wins and blocks the next match
  always @(posedge clk) begin
    if (rst) begin
      count_q <= `TMW_BOTTOM;
      down_q <= 1'b0;
      blk_q <= 1'b0;
    end else if (wr && sel(avs_address, `TMW_ADDR_COUNT)) begin
      count_q <= avs_writedata[7:0];
      blk_q <= 1'b1;
    end else if (tick) begin
      count_q <= count_d;
      down_q <= down_d;
      blk_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  // events raised on a tick; a set beats a same-cycle clear
  wire ovf_ev = tick && (is_pc ? (at_bottom && down_q) :
                is_fast ? at_top : (count_q == `TMW_MAX));
  // compare A flag in clear-on-match mode per period
  // flag set one tick after the equality
  wire cma_ev = tick && match_a;
  wire cmb_ev = tick && match_b;
  wire [2:0] ev = {cmb_ev, cma_ev, ovf_ev};
  wire [2:0] clr = (wr && sel(avs_address, `TMW_ADDR_FLAGS)) ? avs_writedata[2:0] : 3'h0;

  // overflow as count passes MAX to 0x00
  // fast pwm at top; phase correct at bottom
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      always @(posedge clk) begin
        if (rst) begin
          flags_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (clr[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control writes
  // ----------------------------------------
  // settings take effect immediately, not buffered
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 8'h00;
      psc_q <= `TMW_PSC_STOP;
      dir_q <= 2'h0;
    end else if (wr) begin
      if (sel(avs_address, `TMW_ADDR_CTRL)) begin
        ctrl_q <= avs_writedata[7:0];
      end
      if (sel(avs_address, `TMW_ADDR_PRESC)) begin
        psc_q <= avs_writedata[2:0];
      end
      if (sel(avs_address, `TMW_ADDR_DIR)) begin
        dir_q <= avs_writedata[1:0];
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // read data registered; unmapped reads return zero
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= `TMW_RD_ZERO;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_req;
      if (rd_req) begin
        case (avs_address)
          `TMW_ADDR_CTRL: avs_readdata <= {24'h000000, ctrl_q};
          `TMW_ADDR_PRESC: avs_readdata <= {29'h00000000, psc_q};
          `TMW_ADDR_COUNT: avs_readdata <= {24'h000000, count_q};
          `TMW_ADDR_CMPA: avs_readdata <= {24'h000000, is_pwm ? buf_a : compare_value_a};
          `TMW_ADDR_CMPB: avs_readdata <= {24'h000000, is_pwm ? buf_b : compare_value_b};
          `TMW_ADDR_FLAGS: avs_readdata <= {29'h00000000, compare_flag_b,
                                            compare_flag_a, overflow_flag};
          `TMW_ADDR_DIR: avs_readdata <= {28'h0000000, wave_out_b, wave_out_a, dir_q};
          default: avs_readdata <= `TMW_RD_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // pin override
  // ----------------------------------------
  // setting 0 hands the pin back to the port
  // driver only when direction bit selects output
  // the pwm-reserved setting 1 on b also leaves the port in charge
  wire own_a = (compare_output_setting_a != `TMW_SET_OFF) &&
               !(is_pwm && compare_output_setting_a == `TMW_SET_TOGGLE && !waveform_mode_upper_bit);
  wire own_b = (compare_output_setting_b != `TMW_SET_OFF) &&
               !(is_pwm && compare_output_setting_b == `TMW_SET_TOGGLE);
  assign pin_out_a = own_a ? wave_out_a : port_level_a;
  assign pin_out_b = own_b ? wave_out_b : port_level_b;
  assign pin_oe_a = dir_q[0];
  assign pin_oe_b = dir_q[1];
endmodule

// file: hdl/tmw_wave_unit.v
// one compare channel: buffer, match and waveform register
`timescale 1ns/1ps
module tmw_wave_unit (
  // clock and reset
  input wire clk,
  input wire rst,
  // software side
  input wire wr_cmp,
  input wire [7:0] wr_data,
  input wire [1:0] setting,
  input wire toggle_ok,
  // counter state
  input wire tick,
  input wire is_pwm,
  input wire is_fast,
  input wire is_pc,
  input wire count_up,
  input wire [7:0] count_value,
  input wire [7:0] top_value,
  input wire at_top,
  input wire at_bottom,
  input wire block_match,
  // results
  output reg [7:0] compare_value_n,
  output reg [7:0] cmp_buf_q,
  output wire match,
  output reg wave_out_n
);
`include "tmw_defs.vh"
  wire toggle_on = (setting == `TMW_SET_TOGGLE) && toggle_ok;
  wire pwm_set = setting[1];
  wire invert = setting[0];
  wire cmp_is_top = (compare_value_n == top_value);
  assign match = (count_value == compare_value_n) && !block_match;
  // buffered in pwm modes, direct otherwise
  always @(posedge clk) begin
    if (rst) begin
      cmp_buf_q <= `TMW_BOTTOM;
      compare_value_n <= `TMW_BOTTOM;
    end else begin
      if (wr_cmp) begin
        cmp_buf_q <= wr_data;
      end
      if (wr_cmp && !is_pwm) begin
        compare_value_n <= wr_data;
      end else if (is_pwm && tick && ((is_fast && at_bottom) || (is_pc && at_top))) begin
        compare_value_n <= cmp_buf_q;
      end
    end
  end
  // waveform register update, clear/set/toggle per mode
  always @(posedge clk) begin
    if (rst) begin
      wave_out_n <= 1'b0;
    end else if (tick) begin
      if (!is_pwm) begin
        // toggle per match; no action at 0
        if (match && setting == `TMW_SET_TOGGLE) begin
          wave_out_n <= ~wave_out_n;
        end else if (match && pwm_set) begin
          wave_out_n <= invert;
        end
      end else if (toggle_on) begin
        if (match) begin
          wave_out_n <= ~wave_out_n;
        end
      end else if (pwm_set && is_fast) begin
        // match at top ignored, constant level
        if (at_top) begin
          wave_out_n <= ~invert;
        end else if (match && !cmp_is_top) begin
          wave_out_n <= invert;
        end
      end else if (pwm_set && is_pc) begin
        // level forced at top keeps symmetry
        if (at_top && cmp_is_top) begin
          wave_out_n <= ~invert;
        end else if (at_top && count_value > compare_value_n) begin
          wave_out_n <= invert;
        end else if (match && !cmp_is_top && count_value != `TMW_BOTTOM) begin
          // up match clears, down match sets with setting 2; setting 3 reverses both
          // bottom compare ignored, so the level stays constant
          wave_out_n <= count_up ? invert : ~invert;
        end
      end
    end
  end
endmodule

// file: verif/tmw_timer_chk.sv
// port-level assertions for the 8-bit waveform timer
`timescale 1ns/1ps
`include "tmw_defs.vh"
module tmw_timer_chk (
  // clock and reset
  input wire clk,
  input wire rst,
  // register bus, write side
  input wire [3:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  // pins and internal view
  input wire port_level_a,
  input wire port_level_b,
  input wire pin_out_a,
  input wire pin_oe_a,
  input wire pin_out_b,
  input wire [7:0] count_value,
  input wire wave_out_a
);
  // -------------------------
  // shadow of software settings
  // -------------------------
  reg [7:0] ctrl_q;
  reg [7:0] cmpa_q;
  reg [2:0] psc_q;
  reg [2:0] psc_old_q;
  reg dir_q;
  wire wr_en = avs_write && avs_byteenable[0];
  wire [2:0] mode = ctrl_q[2:0];
  wire [1:0] seta = ctrl_q[5:4];
  wire [1:0] setb = ctrl_q[7:6];
  // wait a cycle after a divider change so prescaler latency never matters
  wire run1 = psc_q == `TMW_PSC_1 && psc_old_q == `TMW_PSC_1 && !avs_write;
  wire held = psc_q == `TMW_PSC_STOP && psc_old_q == `TMW_PSC_STOP && !avs_write;
  // follow bus writes
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 8'h00;
      cmpa_q <= 8'h00;
      psc_q <= 3'h0;
      psc_old_q <= 3'h0;
      dir_q <= 1'b0;
    end else begin
      psc_old_q <= psc_q;
      if (wr_en && avs_address == `TMW_ADDR_CTRL) ctrl_q <= avs_writedata[7:0];
      if (wr_en && avs_address == `TMW_ADDR_CMPA) cmpa_q <= avs_writedata[7:0];
      if (wr_en && avs_address == `TMW_ADDR_PRESC) psc_q <= avs_writedata[2:0];
      if (wr_en && avs_address == `TMW_ADDR_DIR) dir_q <= avs_writedata[0];
    end
  end
  // -------------------------
  // assertions
  // -------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ctc_clear_a: assert property (run1 && mode == `TMW_MODE_CTC && count_value == cmpa_q
    |=> count_value == 8'h00) else $error("count did not clear at compare a");
  ctc_step_a: assert property (run1 && mode == `TMW_MODE_CTC && count_value != cmpa_q
    |=> count_value == $past(count_value) + 8'h01) else $error("count did not step by one");
  ctc_toggle_a: assert property (run1 && mode == `TMW_MODE_CTC && seta == 2'h1
    && count_value == cmpa_q |=> wave_out_a != $past(wave_out_a)) else $error("no toggle");
  fast_wrap_a: assert property (run1 && mode == `TMW_MODE_FAST_FF && count_value == 8'hFF
    |=> count_value == 8'h00) else $error("fast count did not wrap");
  fast_set_a: assert property (run1 && mode == `TMW_MODE_FAST_FF && seta == 2'h2
    && count_value == 8'hFF && cmpa_q != 8'hFF |=> wave_out_a) else $error("no set at bottom");
  pc_turn_a: assert property (run1 && mode == `TMW_MODE_PC_FF && count_value == 8'hFF
    |=> count_value == 8'hFE) else $error("count did not turn at top");
  stop_hold_a: assert property (held |=> $stable(count_value))
    else $error("count moved while stopped");
  port_a_pass_a: assert property (seta == 2'h0 |-> pin_out_a == port_level_a)
    else $error("pin a not under port control");
  port_b_pass_a: assert property (setb == 2'h0 |-> pin_out_b == port_level_b)
    else $error("pin b not under port control");
  wave_a_pin_a: assert property (seta[1] |-> pin_out_a == wave_out_a)
    else $error("pin a does not show wave a");
  dir_oe_a: assert property (pin_oe_a == dir_q)
    else $error("pin a enable differs from direction");
  cover property (run1 && mode == `TMW_MODE_CTC && count_value == cmpa_q);
  cover property (mode == `TMW_MODE_PC_FF && count_value == 8'hFF);
  cover property (mode == `TMW_MODE_FAST_A && wave_out_a);
endmodule

bind tmw_timer tmw_timer_chk u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .port_level_a(port_level_a), .port_level_b(port_level_b), .pin_out_a(pin_out_a),
  .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .count_value(count_value),
  .wave_out_a(wave_out_a));

// file: verif/tmw_timer_tb_top.sv
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`include "tmw_defs.vh"
module tmw_timer_tb_top;
  reg clk, rst, avs_read, avs_write, port_level_a, port_level_b;
  reg [3:0] avs_address, avs_byteenable;
  reg [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, wave_out_a, wave_out_b;
  wire [7:0] count_value;
  int err_count = 0, n_compared = 0, cyc = 0, hi_a, hi_b, rs_a, rs_b, i;
  int nv[5] = '{1, 8, 64, 256, 1024};
  // ctrl, cmp a, cmp b, window, high a, high b, rises a, rises b; -1 is unchecked
  int tab[9][8] = '{'{'hE3, 'h40, 'hC0, 512, 130, 126, 2, -1},
    '{'h63, 'h00, 'h10, 512, 2, -1, 2, 0}, '{'h23, 'hFF, 'h00, 512, 512, -1, 0, -1},
    '{'h97, 'h1F, 'h07, 128, 64, 32, 2, -1}, '{'h17, 'h00, 'h00, 128, 64, -1, 64, -1},
    '{'hE1, 'h40, 'h40, 1020, 256, 764, 2, -1}, '{'hE1, 'h00, 'h00, 1020, 0, 1020, 0, -1},
    '{'h21, 'hFF, 'h00, 1020, 1020, -1, 0, -1}, '{'h85, 'h10, 'h08, 64, -1, 32, -1, -1}};
  tmw_timer dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_level_a(port_level_a), .port_level_b(port_level_b), .pin_out_a(pin_out_a),
    .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
    .count_value(count_value), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // moving port levels so a wrong pin source shows; also the hang limit
  always @(posedge clk) begin
    port_level_a <= ~port_level_a;
    port_level_b <= ~port_level_a;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] exp, input [31:0] got);
    begin
      n_compared++;
      if (got !== exp) begin
        err_count++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask
  // measured counts; a negative figure means not checked
  task chkn(input int exp, input int got);
    begin
      if (exp >= 0) chk(exp, got);
    end
  endtask
  // hold the request until waitrequest is seen low at an edge
  // waitrequest is read settled mid-cycle, then the edge that takes the request passes
  task ack;
    int n;
    reg w;
    begin
      n = 0;
      w = 1'b1;
      while (w !== 1'b0 && n < 20) begin
        @(negedge clk);
        w = avs_waitrequest;
        @(posedge clk);
        n++;
      end
      if (w !== 1'b0) err_count++;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d, input [3:0] be = 4'hF);
    begin
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      ack;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdr(input [3:0] a);
    begin
      avs_address <= a;
      avs_read <= 1'b1;
      ack;
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  // high cycles and rising edges of both waves over a window
  task samp(input int w);
    reg pa, pb;
    begin
      hi_a = 0;
      hi_b = 0;
      rs_a = 0;
      rs_b = 0;
      pa = wave_out_a;
      pb = wave_out_b;
      repeat (w) begin
        @(posedge clk);
        hi_a += (wave_out_a === 1'b1);
        hi_b += (wave_out_b === 1'b1);
        rs_a += (wave_out_a === 1'b1 && pa === 1'b0);
        rs_b += (wave_out_b === 1'b1 && pb === 1'b0);
        pa = wave_out_a;
        pb = wave_out_b;
      end
    end
  endtask
  // stop, zero the count, load settings, clear flags, restart
  task cfg(input [7:0] c, input [7:0] a, input [7:0] b, input [2:0] p);
    begin
      wr(`TMW_ADDR_PRESC, 8'h00);
      wr(`TMW_ADDR_COUNT, 8'h00);
      wr(`TMW_ADDR_CTRL, c);
      wr(`TMW_ADDR_CMPA, a);
      wr(`TMW_ADDR_CMPB, b);
      wr(`TMW_ADDR_FLAGS, 8'h07);
      wr(`TMW_ADDR_PRESC, {5'h00, p});
    end
  endtask
  task wait_cnt(input [7:0] v);
    int n;
    begin
      n = 0;
      while (count_value !== v && n < 600) begin
        n++;
        @(posedge clk);
      end
      chk(v, count_value);
    end
  endtask
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    port_level_a = 1'b0;
    port_level_b = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped place, write with lane 0 disabled
    wr(4'hF, 8'h5A);
    wr(`TMW_ADDR_CTRL, 8'h12, 4'hE);
    for (i = 0; i < 8; i++) begin
      rdr(i == 7 ? 4'hF : i[3:0]);
      chk(32'h00000000, rd);
    end
    // toggle on match, period set by compare a and the divider
    for (i = 0; i < 5; i++) begin
      cfg(8'h12, 8'h03, 8'h00, `TMW_PSC_1 + i[2:0]);
      repeat (8 * nv[i] + 8) @(posedge clk);
      samp(16 * nv[i]);
      chkn(8 * nv[i], hi_a);
      chkn(2, rs_a);
    end
    rdr(`TMW_ADDR_FLAGS);
    chk(32'h2, rd & 32'h3);
    wr(`TMW_ADDR_DIR, 8'h03);
    chk(1, pin_oe_a);
    chk(1, pin_oe_b);
    chk(wave_out_a, pin_out_a);
    wr(`TMW_ADDR_DIR, 8'h00);
    chk(0, pin_oe_a);
    chk(0, pin_oe_b);
    wr(`TMW_ADDR_PRESC, 8'h00);
    samp(64);
    chkn(0, rs_a);
    wr(`TMW_ADDR_FLAGS, 8'h07);
    rdr(`TMW_ADDR_FLAGS);
    chk(32'h0, rd);
    // compare a below the count: match missed until after the wrap
    wr(`TMW_ADDR_COUNT, 8'h10);
    rdr(`TMW_ADDR_COUNT);
    chk(32'h10, rd);
    wr(`TMW_ADDR_CMPA, 8'h05);
    wr(`TMW_ADDR_PRESC, 8'h01);
    wait_cnt(8'hFF);
    wait_cnt(8'h05);
    rdr(`TMW_ADDR_FLAGS);
    chk(32'h1, rd & 32'h1);
    // pwm modes, extreme compare values, reserved toggle on b
    for (i = 0; i < 9; i++) begin
      cfg(tab[i][0][7:0], tab[i][1][7:0], tab[i][2][7:0], `TMW_PSC_1);
      repeat (1100) @(posedge clk);
      samp(tab[i][3]);
      chkn(tab[i][4], hi_a);
      chkn(tab[i][5], hi_b);
      chkn(tab[i][6], rs_a);
      chkn(tab[i][7], rs_b);
      rdr(`TMW_ADDR_FLAGS);
      chk(32'h1, rd & 32'h1);
    end
    report_and_stop;
  end
endmodule
